/* rlsc_consts.vh */
// rlsc_consts.vh: state codes, interface codes and serial timing constants
// assumes inclusion by the remote/local state controller, its checker and its bench
`ifndef RLSC_CONSTS_VH
`define RLSC_CONSTS_VH

// one-hot operating states
`define RLSC_ST_LOCAL       4'h1
`define RLSC_ST_LOCAL_LOCK  4'h2
`define RLSC_ST_REMOTE      4'h4
`define RLSC_ST_REMOTE_LOCK 4'h8

// lockout owner codes
`define RLSC_OWN_NONE   2'h0
`define RLSC_OWN_GPIB   2'h1
`define RLSC_OWN_USB    2'h2
`define RLSC_OWN_SER    2'h3

// serial baud range and clock rate
`define RLSC_CLK_HZ     250000000
`define RLSC_BAUD_MIN   9600
`define RLSC_BAUD_MAX   115200
`define RLSC_BAUD_MID1  19200
`define RLSC_BAUD_MID2  38400
`define RLSC_BAUD_MID3  57600

// baud select codes, lowest to highest
`define RLSC_BAUD_9600   3'h0
`define RLSC_BAUD_19200  3'h1
`define RLSC_BAUD_38400  3'h2
`define RLSC_BAUD_57600  3'h3
`define RLSC_BAUD_115200 3'h4

`endif

/* rlsc_remote_local.v */
// rlsc_remote_local.v: remote/local operating state controller with lockout owner
// tracking, front-panel gating and serial bit-rate enable generation.
// assumes all inputs are synchronous one-cycle event pulses or levels on clk.
// ----------------------------------------------------------------
// transition summary
// ----------------------------------------------------------------
// local          -> local lockout  : lockout from any channel, owner recorded
// local          -> remote         : serial remote, gpib listen with ren,
//                                    usb clear, trigger or message-out with ren
// local lockout  -> remote lockout : any remote request, owner kept
// remote         -> remote lockout : lockout from any channel, owner recorded
// remote         -> local          : softkey, serial local, gpib go-to-local,
//                                    usb go-to-local, usb ren fall, cable pull
// remote lockout -> local lockout  : release from the owning channel only
// lockout requests inside a lockout state change nothing
// lockout wins over remote when both land in one cycle
//
// ----------------------------------------------------------------
// input conventions
// ----------------------------------------------------------------
// command and message inputs are one-cycle high pulses
// ren and cable inputs are levels, usb ren and cable edges found here
// all inputs already synchronous to clk
// panel keys are gated here, not latched
//
// ----------------------------------------------------------------
// limitations
// ----------------------------------------------------------------
// no path leaves a lockout state for plain local; only reset clears it
// gpib ren low alone keeps remote; host must send go-to-local
// usb level edges act one cycle after the level moves
// baud divider rounds down, so every rate runs slightly fast
// owner priority on simultaneous lockouts: serial, gpib, usb
// usb cable pull also releases a usb-owned lockout
// remote commands are never blocked in any state
`include "rlsc_consts.vh"
`default_nettype none

module rlsc_remote_local #(
    parameter integer CLK_HZ = `RLSC_CLK_HZ
) (
    input  wire       clk,
    input  wire       reset,
    // front panel
    input  wire       panel_goto_local,
    input  wire       panel_key_valid,
    // serial or ethernet commands
    input  wire       ser_remote_cmd,
    input  wire       ser_local_cmd,
    input  wire       ser_lockout_cmd,
    // gpib
    input  wire       gpib_ren,
    input  wire       gpib_my_listen,
    input  wire       gpib_goto_local,
    input  wire       gpib_lockout,
    // usb test and measurement class
    input  wire       usb_ren_control,
    input  wire       usb_attached,
    input  wire       usb_init_clear,
    input  wire       usb_trigger,
    input  wire       usb_msg_out,
    input  wire       usb_local_lockout,
    input  wire       usb_goto_local,
    // serial port pins and rate
    input  wire [2:0] baud_sel,
    input  wire       ser_tx_data,
    input  wire       ser_rx_pin,
    output reg        ser_tx_pin,
    output reg        ser_rx_data,
    output reg        baud_tick,
    // state outputs
    output reg  [3:0] op_state,
    output reg  [1:0] lock_owner,
    output reg        remote_cmd_enable,
    output wire       panel_key_accept,
    output wire       panel_gtl_accept
);

    // ----------------------------------------------------------------
    // state codes
    // ----------------------------------------------------------------

    // one-hot operating states
    localparam [3:0] ST_LOCAL       = `RLSC_ST_LOCAL;
    localparam [3:0] ST_LOCAL_LOCK  = `RLSC_ST_LOCAL_LOCK;
    localparam [3:0] ST_REMOTE      = `RLSC_ST_REMOTE;
    localparam [3:0] ST_REMOTE_LOCK = `RLSC_ST_REMOTE_LOCK;

    // ----------------------------------------------------------------
    // baud divider
    // ----------------------------------------------------------------

    // cycles per bit at the default clock:
    //   sel 0:  9600 baud, 26041 cycles
    //   sel 1: 19200 baud, 13020 cycles
    //   sel 2: 38400 baud,  6510 cycles
    //   sel 3: 57600 baud,  4340 cycles
    //   sel 4: 115200 baud, 2170 cycles (also unused codes)

    // cycles per bit for a given rate, rounded down
    function [15:0] baud_div;
        input [2:0] sel;
        integer rate;
        integer quot;
        begin
            case (sel)
                `RLSC_BAUD_9600:   rate = `RLSC_BAUD_MIN;
                `RLSC_BAUD_19200:  rate = `RLSC_BAUD_MID1;
                `RLSC_BAUD_38400:  rate = `RLSC_BAUD_MID2;
                `RLSC_BAUD_57600:  rate = `RLSC_BAUD_MID3;
                `RLSC_BAUD_115200: rate = `RLSC_BAUD_MAX;
                default:           rate = `RLSC_BAUD_MAX;
            endcase
            quot     = CLK_HZ / rate;
            baud_div = quot[15:0]; // slowest rate still fits 16 bits
        end
    endfunction

    reg  [15:0] baud_cnt_reg;
    wire [15:0] baud_limit = baud_div(baud_sel);

    // one-cycle bit-rate enable for the serial engine
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            baud_cnt_reg <= 16'h0000;
            baud_tick    <= 1'b0;
        end else if (baud_cnt_reg >= baud_limit - 16'h0001) begin
            baud_cnt_reg <= 16'h0000;
            baud_tick    <= 1'b1;
        end else begin
            baud_cnt_reg <= baud_cnt_reg + 16'h0001;
            baud_tick    <= 1'b0;
        end
    end

    // terminal-equipment pin roles: we drive transmit, sample receive
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            ser_tx_pin  <= 1'b1;
            ser_rx_data <= 1'b1;
        end else begin
            ser_tx_pin  <= ser_tx_data;
            ser_rx_data <= ser_rx_pin;
        end
    end

    // ----------------------------------------------------------------
    // event decode
    // ----------------------------------------------------------------

    reg usb_ren_d_reg;
    reg usb_att_d_reg;

    // edge history for usb level signals
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            usb_ren_d_reg <= 1'b0;
            usb_att_d_reg <= 1'b0;
        end else begin
            usb_ren_d_reg <= usb_ren_control;
            usb_att_d_reg <= usb_attached;
        end
    end

    wire usb_ren_fall = usb_ren_d_reg & ~usb_ren_control;
    wire usb_unplug   = usb_att_d_reg & ~usb_attached;

    // remote requests per channel
    wire gpib_remote = gpib_ren & gpib_my_listen;
    wire usb_remote  = usb_ren_control &
                       (usb_init_clear | usb_trigger | usb_msg_out);
    wire any_remote  = ser_remote_cmd | gpib_remote | usb_remote;

    // lockout requests per channel
    wire usb_lock    = usb_local_lockout & usb_ren_control;
    wire any_lock    = ser_lockout_cmd | gpib_lockout | usb_lock;

    // go-to-local per channel, and ren drop
    wire usb_leave   = usb_goto_local | usb_ren_fall | usb_unplug;
    wire gpib_leave  = gpib_goto_local;

    // owner that a new lockout records, serial first
    wire [1:0] new_owner = ser_lockout_cmd ? `RLSC_OWN_SER :
                           gpib_lockout    ? `RLSC_OWN_GPIB :
                           usb_lock        ? `RLSC_OWN_USB : `RLSC_OWN_NONE;

    // release to local lockout, only from the owning channel
    reg owner_release;
    always @* begin
        case (lock_owner)
            `RLSC_OWN_SER:  owner_release = ser_local_cmd;
            `RLSC_OWN_GPIB: owner_release = gpib_leave;
            `RLSC_OWN_USB:  owner_release = usb_goto_local | usb_unplug;
            default:        owner_release = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------

    reg [3:0] state_next;
    reg [1:0] owner_next;

    always @* begin
        state_next = op_state;
        owner_next = lock_owner;
        case (op_state)
            // local: lockout first, then remote
            ST_LOCAL: begin
                if (any_lock) begin
                    state_next = `RLSC_ST_LOCAL_LOCK;
                    owner_next = new_owner;
                end else if (any_remote) begin
                    state_next = `RLSC_ST_REMOTE;
                end
            end
            // local lockout: only remote requests move it
            ST_LOCAL_LOCK: begin
                if (any_remote) begin
                    state_next = `RLSC_ST_REMOTE_LOCK;
                end
            end
            // remote: lockout first, then any go-to-local
            ST_REMOTE: begin
                if (any_lock) begin
                    state_next = `RLSC_ST_REMOTE_LOCK;
                    owner_next = new_owner;
                end else if (panel_goto_local | ser_local_cmd | gpib_leave |
                             usb_leave | ~gpib_ren & usb_ren_fall) begin
                    state_next = `RLSC_ST_LOCAL;
                end
            end
            // remote lockout: only the owner releases
            ST_REMOTE_LOCK: begin
                if (owner_release) begin
                    state_next = `RLSC_ST_LOCAL_LOCK;
                end
            end
            default: begin
                state_next = `RLSC_ST_LOCAL;
                owner_next = `RLSC_OWN_NONE;
            end
        endcase
    end

    // state registers, local with no owner after reset
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            op_state   <= `RLSC_ST_LOCAL;
            lock_owner <= `RLSC_OWN_NONE;
        end else begin
            op_state   <= state_next;
            lock_owner <= owner_next;
        end
    end

    // remote commands always execute once decoded
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            remote_cmd_enable <= 1'b0;
        end else begin
            remote_cmd_enable <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // front-panel gating
    // ----------------------------------------------------------------

    // state decode shared by the gating terms
    wire in_local_any = op_state[0] | op_state[1];
    wire in_remote    = op_state[2];

    // ordinary keys only in the two local states
    assign panel_key_accept = panel_key_valid & in_local_any;
    // return-to-local key only in plain remote; dead under remote lockout
    assign panel_gtl_accept = panel_goto_local & in_remote;

endmodule // rlsc_remote_local

`default_nettype wire

/* rlsc_remote_local_checker.sv */
// rlsc_remote_local_checker.sv: state, panel gating and lockout owner checks
// assumes binding onto rlsc_remote_local, sampled on rising clk
`include "rlsc_consts.vh"
`default_nettype none
module rlsc_remote_local_checker (
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       panel_goto_local,
    input wire logic       panel_key_valid,
    input wire logic       ser_remote_cmd,
    input wire logic       ser_local_cmd,
    input wire logic       ser_lockout_cmd,
    input wire logic       gpib_lockout,
    input wire logic       usb_local_lockout,
    input wire logic       usb_attached,
    input wire logic [3:0] op_state,
    input wire logic [1:0] lock_owner,
    input wire logic       panel_key_accept,
    input wire logic       panel_gtl_accept
);
    // ----------------------------------------
    // state decode and properties
    // ----------------------------------------
    wire logic loc  = op_state == `RLSC_ST_LOCAL;
    wire logic locl = op_state == `RLSC_ST_LOCAL_LOCK;
    wire logic rem  = op_state == `RLSC_ST_REMOTE;
    wire logic reml = op_state == `RLSC_ST_REMOTE_LOCK;
    wire logic anyl = ser_lockout_cmd || gpib_lockout || usb_local_lockout;
    wire logic sown = lock_owner == `RLSC_OWN_SER;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_ONE_STATE: assert property ($onehot(op_state))
        else $error("state not one-hot");
    AST_RESET_LOCAL: assert property ($fell(reset) |-> loc && lock_owner == 2'h0)
        else $error("not local after reset");
    AST_KEY_GATE: assert property (panel_key_accept == (panel_key_valid && (loc || locl)))
        else $error("panel key gating wrong");
    AST_GTL_KEY: assert property (rem && panel_goto_local && !anyl |-> panel_gtl_accept ##1 loc)
        else $error("softkey did not return local");
    AST_LOCK_PANEL: assert property (reml |-> !panel_gtl_accept && !panel_key_accept)
        else $error("panel live in remote lockout");
    AST_SER_REMOTE: assert property (loc && ser_remote_cmd && !anyl |=> rem)
        else $error("remote command ignored");
    AST_LOCK_REMOTE: assert property (locl && ser_remote_cmd |=> reml)
        else $error("local lockout did not go remote lockout");
    AST_LOCKOUT_SER: assert property (loc && ser_lockout_cmd |=> locl && sown)
        else $error("lockout not applied");
    AST_OWNER_KEEP: assert property (lock_owner != 2'h0 |=> $stable(lock_owner))
        else $error("owner changed");
    AST_NON_OWNER: assert property (reml && sown && !ser_local_cmd |=> reml)
        else $error("non-owner released lockout");
    AST_OWNER_FREE: assert property (reml && sown && ser_local_cmd |=> locl)
        else $error("owner release ignored");
    AST_UNPLUG: assert property (rem && $fell(usb_attached) && !anyl |-> ##[1:3] loc)
        else $error("unplug did not return local");
    COV_REML: cover property (locl ##1 reml);
    COV_UNPLUG: cover property (rem && $fell(usb_attached));
    COV_GTL: cover property (panel_gtl_accept);
endmodule // rlsc_remote_local_checker
bind rlsc_remote_local rlsc_remote_local_checker chk_u (.clk(clk), .reset(reset),
    .panel_goto_local(panel_goto_local), .panel_key_valid(panel_key_valid),
    .ser_remote_cmd(ser_remote_cmd), .ser_local_cmd(ser_local_cmd),
    .ser_lockout_cmd(ser_lockout_cmd), .gpib_lockout(gpib_lockout),
    .usb_local_lockout(usb_local_lockout), .usb_attached(usb_attached),
    .op_state(op_state), .lock_owner(lock_owner),
    .panel_key_accept(panel_key_accept), .panel_gtl_accept(panel_gtl_accept));
`default_nettype wire

/* rlsc_host_model.sv */
// rlsc_host_model.sv: remote controller issuing command pulses and levels
// assumes the bench calls pulse and lvl after reset release
`default_nettype none
module rlsc_host_model (
    input  wire logic        clk,
    output var  logic [10:0] evt,
    output var  logic        gpib_ren,
    output var  logic        usb_ren_control,
    output var  logic        usb_attached
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------
    // idle levels and request tasks
    // ----------------------------------------
    initial begin
        evt = 11'h000;
        gpib_ren = 1'b0;
        usb_ren_control = 1'b0;
        usb_attached = 1'b1;
    end
    // one-cycle message pulse on one channel
    task automatic pulse(input int k);
        @(posedge clk);
        #1 evt[k] = 1'b1;
        @(posedge clk);
        #1 evt[k] = 1'b0;
    endtask
    // bus enable and cable levels
    task automatic lvl(input logic r, input logic u, input logic a);
        @(posedge clk);
        #1 gpib_ren = r;
        usb_ren_control = u;
        usb_attached = a;
    endtask
endmodule // rlsc_host_model
`default_nettype wire

/* rlsc_remote_local_bench.sv */
// rlsc_remote_local_bench.sv: self-checking bench of the remote/local controller
// assumes the host model drives remote channels and the checker is bound
`include "rlsc_consts.vh"
`default_nettype none
module rlsc_remote_local_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SREM = 0, SLOC = 1, SLCK = 2, GLSN = 3, GGTL = 4, GLLO = 5;
    localparam int UCLR = 6, UTRG = 7, UMSG = 8, ULLO = 9, UGTL = 10;
    logic        clk, reset, pgtl, pkey, tx_d, rx_p;
    logic [2:0]  baud_sel;
    logic [10:0] evt;
    logic        gren, urc, uatt, tx_p, rx_d, tick, rce, kacc, gacc;
    logic [3:0]  op_state;
    logic [1:0]  owner;
    int          n_errors = 0;
    int          checked = 0;
    // ----------------------------------------
    // design, far side and clock
    // ----------------------------------------
    rlsc_remote_local dut_u (.clk(clk), .reset(reset), .panel_goto_local(pgtl),
        .panel_key_valid(pkey), .ser_remote_cmd(evt[0]), .ser_local_cmd(evt[1]),
        .ser_lockout_cmd(evt[2]), .gpib_ren(gren), .gpib_my_listen(evt[3]),
        .gpib_goto_local(evt[4]), .gpib_lockout(evt[5]), .usb_ren_control(urc),
        .usb_attached(uatt), .usb_init_clear(evt[6]), .usb_trigger(evt[7]),
        .usb_msg_out(evt[8]), .usb_local_lockout(evt[9]), .usb_goto_local(evt[10]),
        .baud_sel(baud_sel), .ser_tx_data(tx_d), .ser_rx_pin(rx_p), .ser_tx_pin(tx_p),
        .ser_rx_data(rx_d), .baud_tick(tick), .op_state(op_state), .lock_owner(owner),
        .remote_cmd_enable(rce), .panel_key_accept(kacc), .panel_gtl_accept(gacc));
    rlsc_host_model pm (.clk(clk), .evt(evt), .gpib_ren(gren), .usb_ren_control(urc),
        .usb_attached(uatt));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("mismatches %0d of %0d compares", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic ev(input int k, input logic [3:0] exp);
        pm.pulse(k);
        chk(op_state, exp);
    endtask
    task automatic press(input logic gtl, input logic exp);
        @(posedge clk);
        #1 pgtl = gtl;
        pkey = !gtl;
        #1 chk(gtl ? gacc : kacc, exp);
        @(posedge clk);
        #1 pgtl = 1'b0;
        pkey = 1'b0;
    endtask
    task automatic t_baud(input logic [2:0] sel, input int rate);
        int n;
        @(posedge clk);
        #1 baud_sel = sel;
        repeat (3) begin
            n = 0;
            do begin
                @(posedge clk);
                #1 n++;
            end while (tick !== 1'b1 && n < 30000);
        end
        chk(n, `RLSC_CLK_HZ / rate);
    endtask
    task automatic t_serial;
        @(posedge clk);
        #1 {tx_d, rx_p} = 2'b00;
        @(posedge clk);
        #1 chk({tx_p, rx_d}, 2'b00);
        chk(rce, 1'b1);
        {tx_d, rx_p} = 2'b11;
        @(posedge clk);
        #1 chk({tx_p, rx_d}, 2'b11);
    endtask
    task automatic t_usb_lock;
        @(posedge clk);
        #1 reset = 1'b1;
        repeat (4) @(posedge clk);
        #1 reset = 1'b0;
        chk({op_state, owner}, 6'h04);
        pm.lvl(1'b0, 1'b1, 1'b1);
        ev(ULLO, `RLSC_ST_LOCAL_LOCK);
        chk(owner, `RLSC_OWN_USB);
        ev(UMSG, `RLSC_ST_REMOTE_LOCK);
        ev(SLOC, `RLSC_ST_REMOTE_LOCK);
        ev(UGTL, `RLSC_ST_LOCAL_LOCK);
    endtask
    task automatic t_remote;
        ev(SREM, `RLSC_ST_REMOTE);
        press(1'b0, 1'b0);
        press(1'b1, 1'b1);
        press(1'b0, 1'b1);
        pm.lvl(1'b1, 1'b0, 1'b1);
        ev(GLSN, `RLSC_ST_REMOTE);
        ev(GGTL, `RLSC_ST_LOCAL);
        ev(UTRG, `RLSC_ST_LOCAL);
        pm.lvl(1'b1, 1'b1, 1'b1);
        ev(UMSG, `RLSC_ST_REMOTE);
        ev(UGTL, `RLSC_ST_LOCAL);
        ev(UCLR, `RLSC_ST_REMOTE);
        pm.lvl(1'b1, 1'b1, 1'b0);
        repeat (4) @(posedge clk);
        #1 chk(op_state, `RLSC_ST_LOCAL);
    endtask
    task automatic t_lockout;
        ev(SLCK, `RLSC_ST_LOCAL_LOCK);
        press(1'b0, 1'b1);
        ev(SREM, `RLSC_ST_REMOTE_LOCK);
        press(1'b1, 1'b0);
        press(1'b0, 1'b0);
        ev(GGTL, `RLSC_ST_REMOTE_LOCK);
        ev(SLOC, `RLSC_ST_LOCAL_LOCK);
        ev(GLLO, `RLSC_ST_LOCAL_LOCK);
        chk(owner, `RLSC_OWN_SER);
    endtask
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        {reset, pgtl, pkey, tx_d, rx_p, baud_sel} = 8'h9c;
        repeat (4) @(posedge clk);
        #1 reset = 1'b0;
        chk({op_state, owner, tx_p}, 7'h09);
        t_serial;
        t_baud(`RLSC_BAUD_115200, `RLSC_BAUD_MAX);
        t_baud(`RLSC_BAUD_57600, `RLSC_BAUD_MID3);
        t_remote;
        t_lockout;
        t_usb_lock;
        conclude;
    end
    initial begin
        #200000;
        n_errors++;
        conclude;
    end
endmodule // rlsc_remote_local_bench
`default_nettype wire
